/* hdl/tec8_pkg.sv */
// constants shared by the 8-bit timer/event counter
package tec8_pkg;
  // -----------------------------------------------------------------
  // apb register map (byte addresses)
  // -----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_CONTROL = 12'h000; // timer_control
  localparam logic [11:0] OFS_COUNT = 12'h004; // timer_count_preload
  localparam logic [11:0] OFS_STATUS = 12'h008; // sticky events, read clears
  localparam logic [11:0] OFS_MASK = 12'h00c; // interrupt enables
  // -----------------------------------------------------------------
  // timer_control field positions and reset value
  // -----------------------------------------------------------------
  localparam int unsigned MODE_HI = 7; // mode_field msb
  localparam int unsigned MODE_LO = 6; // mode_field lsb
  localparam int unsigned SRC_BIT = 5; // clock_source_select
  localparam int unsigned RUN_BIT = 4; // run_enable
  localparam int unsigned EDGE_BIT = 3; // edge_polarity
  localparam int unsigned PSC_HI = 2; // prescale_field msb
  localparam int unsigned PSC_LO = 0; // prescale_field lsb
  localparam logic [7:0] CONTROL_RESET = 8'h08; // only edge_polarity set
  localparam logic [7:0] COUNT_RESET = 8'h00; // counter and preload
  localparam logic [7:0] COUNT_FULL = 8'hff; // overflow point
  localparam logic [7:0] COUNT_ONE = 8'h01; // increment
  // -----------------------------------------------------------------
  // mode_field codes
  // -----------------------------------------------------------------
  localparam logic [1:0] MODE_UNUSED = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;
  // -----------------------------------------------------------------
  // status / mask layout
  // -----------------------------------------------------------------
  localparam int unsigned EVT_W = 2;
  localparam int unsigned EVT_OVF = 0; // counter overflow
  localparam int unsigned EVT_CAP = 1; // pulse capture finished
  localparam logic [1:0] EVT_RESET = 2'h0;
  // -----------------------------------------------------------------
  // prescaler
  // -----------------------------------------------------------------
  localparam int unsigned DIV_W = 7; // up to divide by 128
  localparam logic [6:0] DIV_ONES = 7'h7f;
  localparam logic [6:0] DIV_RESET = 7'h00;
  localparam logic [6:0] DIV_ONE = 7'h01;
  // pulse capture sequencing
  typedef enum logic [0:0] {cap_armed, cap_measuring} tec8_cap_e;
endpackage

/* hdl/tec8_timer.sv */
// 8-bit timer/event counter with apb registers and overflow interrupt
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - eight-bit counter counts internal ticks or edges
// - clock_source_select picks system or sub clock
// - prescale_field divides base clock by power two
// - mode_field: event, interval timer, pulse capture
// - event mode counts external_timer_input edges
// - edge_polarity zero rising, one falling edge
// - capture starts on one edge, stops opposite
// - run_enable low holds the counter still
// - overflow past ff interrupts and reloads preload
// - write while stopped loads preload and counter
// - write while running loads only preload
// - count register reads the live count
// - event mode ignores clock source and prescale
// - reset: control 08, counter preload zero
// - timer counts prescaled clock falling transitions
// - capture end clears run_enable by hardware
// - stopped capture ignores further input edges
// - armed capture waits for first active edge
module tec8_timer (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tec8_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sub_clock,
  input wire logic external_timer_input,
  output logic irq
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [7:0] timer_control; // mode, source, run, edge, prescale
  logic [7:0] preload; // reload value
  logic [7:0] count; // live counter
  logic [tec8_pkg::EVT_W-1:0] int_status; // sticky events
  logic [tec8_pkg::EVT_W-1:0] int_mask; // interrupt enables
  logic [tec8_pkg::DIV_W-1:0] div_cnt; // prescaler counter
  logic sub_prev; // last sub clock level
  logic ext_meta; // sync stage one
  logic ext_sync; // sync stage two
  logic ext_prev; // for edge detect
  tec8_pkg::tec8_cap_e cap_state; // pulse capture phase

  // -----------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------
  wire access = psel & penable; // access phase
  wire done = access & pready; // transfer completes here
  wire wr_ev = done & pwrite;
  wire rd_ev = done & ~pwrite;
  wire sel_ctrl = paddr == tec8_pkg::OFS_CONTROL;
  wire sel_count = paddr == tec8_pkg::OFS_COUNT;
  wire sel_status = paddr == tec8_pkg::OFS_STATUS;
  wire sel_mask = paddr == tec8_pkg::OFS_MASK;
  wire mapped = sel_ctrl | sel_count | sel_status | sel_mask;
  wire ctrl_wr = wr_ev & sel_ctrl;
  wire cnt_wr = wr_ev & sel_count;
  wire mask_wr = wr_ev & sel_mask;
  wire stat_rd = rd_ev & sel_status;
  // read data; count reads live value
  wire [7:0] rd_byte = sel_ctrl ? timer_control :
                       sel_count ? count :
                       sel_status ? {6'h00, int_status} :
                       sel_mask ? {6'h00, int_mask} : 8'h00;
  wire [31:0] next_prdata = {24'h000000, rd_byte};

  // -----------------------------------------------------------------
  // control fields
  // -----------------------------------------------------------------
  wire [1:0] mode = timer_control[tec8_pkg::MODE_HI:tec8_pkg::MODE_LO];
  wire src_sub = timer_control[tec8_pkg::SRC_BIT];
  wire run = timer_control[tec8_pkg::RUN_BIT];
  wire edge_pol = timer_control[tec8_pkg::EDGE_BIT];
  wire [2:0] psc = timer_control[tec8_pkg::PSC_HI:tec8_pkg::PSC_LO];
  wire m_event = mode == tec8_pkg::MODE_EVENT;
  wire m_timer = mode == tec8_pkg::MODE_TIMER;
  wire m_capture = mode == tec8_pkg::MODE_CAPTURE;

  // -----------------------------------------------------------------
  // internal base clock and prescaler
  // -----------------------------------------------------------------
  // sub clock pulse on its high-to-low transition
  wire sub_tick = sub_prev & ~sub_clock;
  // system clock gives a pulse every mclk cycle
  wire base_tick = src_sub ? sub_tick : 1'b1;
  // low psc bits of the divider must all be ones
  wire [6:0] div_mask = ~(tec8_pkg::DIV_ONES << psc);
  // prescaled clock falls once every 2**psc base pulses
  wire psc_tick = base_tick & ((div_cnt & div_mask) == div_mask);

  // -----------------------------------------------------------------
  // external input edges
  // -----------------------------------------------------------------
  wire ext_rise = ext_sync & ~ext_prev;
  wire ext_fall = ~ext_sync & ext_prev;
  // event counted edge: 0 rising, 1 falling
  wire evt_edge = edge_pol ? ext_fall : ext_rise;
  // capture start: 0 falling, 1 rising; stop is the other one
  wire cap_start = edge_pol ? ext_rise : ext_fall;
  wire cap_stop = edge_pol ? ext_fall : ext_rise;
  wire measuring = cap_state == tec8_pkg::cap_measuring;
  // capture ends when the input returns to its original level
  wire cap_end = run & m_capture & measuring & cap_stop;

  // -----------------------------------------------------------------
  // count advance and next values
  // -----------------------------------------------------------------
  // event mode ignores source and prescale; run gates every mode
  wire adv = run & ((m_event & evt_edge) |
                    (m_timer & psc_tick) |
                    (m_capture & measuring & psc_tick));
  wire ovf = adv & (count == tec8_pkg::COUNT_FULL);
  wire [7:0] count_inc = 8'(count + tec8_pkg::COUNT_ONE);
  wire [7:0] next_count = (cnt_wr & ~run) ? pwdata[7:0] :
                          ovf ? preload :
                          adv ? count_inc : count;
  // hardware clears run at capture end; a control write wins
  wire next_run = ctrl_wr ? pwdata[tec8_pkg::RUN_BIT] :
                  (cap_end ? 1'b0 : run);
  wire [7:0] next_control = ctrl_wr ?
                            {pwdata[7:5], next_run, pwdata[3:0]} :
                            {timer_control[7:5], next_run, timer_control[3:0]};
  // events set, read clears only bits returned; set wins
  wire [1:0] evt_set = {cap_end, ovf};
  wire [1:0] evt_clr = stat_rd ? prdata[tec8_pkg::EVT_W-1:0] : 2'h0;
  wire [1:0] next_status = (int_status & ~evt_clr) | evt_set;
  wire [6:0] next_div = base_tick ? 7'(div_cnt + tec8_pkg::DIV_ONE) : div_cnt;

  // -----------------------------------------------------------------
  // apb response registers
  // -----------------------------------------------------------------
  // one wait state: data, error and pready latched on the same edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= ~mapped;
      end
    end
  end

  // -----------------------------------------------------------------
  // control and data registers
  // -----------------------------------------------------------------
  // reset values per field
  always_ff @(posedge mclk) begin
    if (reset) begin
      timer_control <= tec8_pkg::CONTROL_RESET;
      preload <= tec8_pkg::COUNT_RESET;
      count <= tec8_pkg::COUNT_RESET;
    end else if (ce) begin
      timer_control <= next_control;
      count <= next_count;
      if (cnt_wr) begin
        preload <= pwdata[7:0];
      end
    end
  end

  // -----------------------------------------------------------------
  // events and interrupt
  // -----------------------------------------------------------------
  // irq follows masked status one cycle later
  always_ff @(posedge mclk) begin
    if (reset) begin
      int_status <= tec8_pkg::EVT_RESET;
      int_mask <= tec8_pkg::EVT_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      int_status <= next_status;
      if (mask_wr) begin
        int_mask <= pwdata[tec8_pkg::EVT_W-1:0];
      end
      irq <= |(int_status & int_mask);
    end
  end

  // -----------------------------------------------------------------
  // prescaler and input sampling
  // -----------------------------------------------------------------
  // two-stage synchroniser, edge detect on second stage
  always_ff @(posedge mclk) begin
    if (reset) begin
      div_cnt <= tec8_pkg::DIV_RESET;
      sub_prev <= 1'b0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else if (ce) begin
      div_cnt <= next_div;
      sub_prev <= sub_clock;
      ext_meta <= external_timer_input;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // -----------------------------------------------------------------
  // pulse capture sequencer
  // -----------------------------------------------------------------
  // armed until the start edge, measuring until the stop edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      cap_state <= tec8_pkg::cap_armed;
    end else if (ce) begin
      if (!run || !m_capture) begin
        cap_state <= tec8_pkg::cap_armed;
      end else begin
        unique case (cap_state)
          tec8_pkg::cap_armed: begin
            if (cap_start) begin
              cap_state <= tec8_pkg::cap_measuring;
            end
          end
          tec8_pkg::cap_measuring: begin
            if (cap_stop) begin
              cap_state <= tec8_pkg::cap_armed;
            end
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_count_step: assert property (@(posedge mclk) disable iff (reset)
    ce && adv && count != tec8_pkg::COUNT_FULL |=> count == 8'($past(count) + 8'h01))
    else $error("counter did not step by one");

  a_overflow_reload: assert property (@(posedge mclk) disable iff (reset)
    ce && adv && count == tec8_pkg::COUNT_FULL
    |=> count == $past(preload) && int_status[tec8_pkg::EVT_OVF]
    ##1 (irq || !$past(int_mask[tec8_pkg::EVT_OVF])))
    else $error("overflow did not reload or flag");

  a_hold_stopped: assert property (@(posedge mclk) disable iff (reset)
    ce && !run && !cnt_wr |=> $stable(count))
    else $error("stopped counter moved");

  a_write_stopped: assert property (@(posedge mclk) disable iff (reset)
    ce && cnt_wr && !run |=> count == $past(pwdata[7:0]) && preload == count)
    else $error("stopped write did not load both");

  a_write_running: assert property (@(posedge mclk) disable iff (reset)
    ce && cnt_wr && run && !adv |=> $stable(count) && preload == $past(pwdata[7:0]))
    else $error("running write touched the counter");

  a_event_no_clock: assert property (@(posedge mclk) disable iff (reset)
    ce && run && m_event && !evt_edge && !cnt_wr |=> $stable(count))
    else $error("event mode counted without an edge");

  a_capture_armed: assert property (@(posedge mclk) disable iff (reset)
    ce && run && m_capture && !measuring && !cnt_wr |=> $stable(count))
    else $error("armed capture counted early");

  a_capture_stop: assert property (@(posedge mclk) disable iff (reset)
    ce && cap_end && !ctrl_wr |=> !run && int_status[tec8_pkg::EVT_CAP])
    else $error("capture end did not clear run");

  a_reset_values: assert property (@(posedge mclk)
    $past(reset) |-> timer_control == tec8_pkg::CONTROL_RESET && count == 8'h00)
    else $error("wrong reset values");

  a_sync_edge: assert property (@(posedge mclk) disable iff (reset)
    ce && ext_rise |-> $past(ext_meta))
    else $error("edge not from synchroniser");

  a_sync_chain: assert property (@(posedge mclk) disable iff (reset)
    ce |=> ext_sync == $past(ext_meta))
    else $error("second sync stage skipped");

  a_ready_pulse: assert property (@(posedge mclk) disable iff (reset)
    ce && pready |=> !pready)
    else $error("pready stood longer than one cycle");

  a_ready_wait: assert property (@(posedge mclk) disable iff (reset)
    ce && access && !pready |=> pready)
    else $error("pready missing after one wait state");

  a_unmapped_err: assert property (@(posedge mclk) disable iff (reset)
    ce && access && !pready && !mapped |=> pslverr)
    else $error("unmapped access not flagged");

  a_mapped_ok: assert property (@(posedge mclk) disable iff (reset)
    ce && access && !pready && mapped |=> !pslverr)
    else $error("mapped access flagged as error");

  a_unused_mode: assert property (@(posedge mclk) disable iff (reset)
    ce && mode == tec8_pkg::MODE_UNUSED && !cnt_wr |=> $stable(count))
    else $error("unused mode advanced the counter");

  a_timer_tick: assert property (@(posedge mclk) disable iff (reset)
    ce && run && m_timer && !psc_tick |=> $stable(count))
    else $error("timer counted without a prescaled tick");

  a_sub_source: assert property (@(posedge mclk) disable iff (reset)
    ce && run && m_timer && src_sub && !sub_tick |=> $stable(count))
    else $error("sub clock source counted without a sub tick");

  a_psc_bypass: assert property (@(posedge mclk) disable iff (reset)
    ce && run && m_timer && !src_sub && ~|psc && count != tec8_pkg::COUNT_FULL
    |=> count == 8'($past(count) + 8'h01))
    else $error("undivided timer missed a cycle");

  a_control_write: assert property (@(posedge mclk) disable iff (reset)
    ce && ctrl_wr |=> timer_control == $past(pwdata[7:0]))
    else $error("control write not taken");

  a_preload_write: assert property (@(posedge mclk) disable iff (reset)
    ce && cnt_wr |=> preload == $past(pwdata[7:0]))
    else $error("preload write not taken");

  a_run_capture: assert property (@(posedge mclk) disable iff (reset)
    ce && run && m_capture && !cap_end && !ctrl_wr |=> run)
    else $error("run cleared without capture end");

  a_run_software: assert property (@(posedge mclk) disable iff (reset)
    ce && run && !m_capture && !ctrl_wr |=> run)
    else $error("run cleared by hardware outside capture");

  a_stopped_idle: assert property (@(posedge mclk) disable iff (reset)
    ce && !run |=> !measuring)
    else $error("stopped capture still measuring");

  a_irq_quiet: assert property (@(posedge mclk) disable iff (reset)
    ce && !(|(int_status & int_mask)) |=> !irq)
    else $error("interrupt without unmasked event");

  a_ce_freeze: assert property (@(posedge mclk) disable iff (reset)
    !ce |=> $stable(count) && $stable(timer_control))
    else $error("state moved with clock enable low");

endmodule

`default_nettype wire

/* sim/tec8_pulse_src.sv */
// external pulse source model driving the timer input pin
`timescale 1ns/100ps
`default_nettype none
module tec8_pulse_src (
  input wire logic mclk,
  output logic pin
);
  // ---------------------------------------------------------------
  // pin level sequencing, changed only just after a rising edge
  // ---------------------------------------------------------------
  initial pin = 1'b0; // idle low until told otherwise

  // drive a level and keep it for a number of cycles
  task automatic hold(input logic v, input int cycles);
    pin <= v;
    repeat (cycles) @(posedge mclk);
  endtask

  // invert the pin n times, three cycles per level keeps the width legal
  task automatic toggles(input int n);
    for (int i = 0; i < n; i++) begin
      hold(~pin, 3);
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// self-checking testbench for the 8-bit timer/event counter
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ---------------------------------------------------------------
  // signals and bookkeeping
  // ---------------------------------------------------------------
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, irq, sub_clock, ext_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v, a_v;
  logic rd_e;
  int failures, check_count, cyc, c0;
  typedef struct {logic [7:0] ctrl; int tog; int len; logic [7:0] exp;} tec8_row_s;
  tec8_row_s rows [14];

  tec8_timer u_tec8_timer (.mclk(mclk), .reset(reset), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sub_clock(sub_clock),
    .external_timer_input(ext_pin), .irq(irq));
  tec8_pulse_src u_tec8_pulse_src (.mclk(mclk), .pin(ext_pin));

  // ---------------------------------------------------------------
  // clock, slow sub clock (period 4) and hang guard
  // ---------------------------------------------------------------
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    sub_clock <= cyc[1];
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 40) begin
      n++;
      @(posedge mclk);
    end
    if (n == 40) failures++;
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    check(rd_v, exp);
  endtask

  task automatic final_report();
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    mclk = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; sub_clock = 1'b0; cyc = 0;
    failures = 0; check_count = 0;
    // ctrl, pin toggles, window, expected advance
    rows = '{'{8'h90, 0, 16, 8'h10}, '{8'h91, 0, 32, 8'h10}, '{8'h92, 0, 64, 8'h10},
      '{8'h93, 0, 128, 8'h10}, '{8'h94, 0, 256, 8'h10}, '{8'h95, 0, 512, 8'h10},
      '{8'h96, 0, 1024, 8'h10}, '{8'h97, 0, 1024, 8'h08}, '{8'hb0, 0, 32, 8'h08},
      '{8'hb1, 0, 64, 8'h08}, '{8'h77, 3, 40, 8'h02}, '{8'h58, 3, 40, 8'h01},
      '{8'h10, 0, 40, 8'h00}, '{8'h80, 0, 40, 8'h00}};
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rdchk(tec8_pkg::OFS_CONTROL, 32'h08);
    rdchk(tec8_pkg::OFS_COUNT, 32'h00);
    rdchk(tec8_pkg::OFS_STATUS, 32'h00);
    rdchk(tec8_pkg::OFS_MASK, 32'h00);
    // counting rate per row, measured between two live reads
    foreach (rows[i]) begin
      apb(1'b1, tec8_pkg::OFS_CONTROL, rows[i].ctrl & 8'hef);
      apb(1'b1, tec8_pkg::OFS_COUNT, 8'h00);
      u_tec8_pulse_src.hold(1'b0, 4);
      apb(1'b1, tec8_pkg::OFS_CONTROL, rows[i].ctrl);
      c0 = cyc;
      apb(1'b0, tec8_pkg::OFS_COUNT, 8'h00);
      a_v = rd_v;
      u_tec8_pulse_src.toggles(rows[i].tog);
      while (cyc < c0 + rows[i].len) @(posedge mclk);
      apb(1'b0, tec8_pkg::OFS_COUNT, 8'h00);
      check(rd_v - a_v, {24'h0, rows[i].exp});
    end
    // pulse capture, idle high, counts the low phase once
    apb(1'b1, tec8_pkg::OFS_CONTROL, 8'hc0);
    apb(1'b1, tec8_pkg::OFS_COUNT, 8'h00);
    u_tec8_pulse_src.hold(1'b1, 6);
    apb(1'b1, tec8_pkg::OFS_CONTROL, 8'hd0);
    u_tec8_pulse_src.hold(1'b1, 10);
    rdchk(tec8_pkg::OFS_COUNT, 32'h00);
    u_tec8_pulse_src.hold(1'b0, 20);
    u_tec8_pulse_src.hold(1'b1, 10);
    apb(1'b0, tec8_pkg::OFS_COUNT, 8'h00);
    a_v = rd_v;
    check({31'h0, a_v >= 32'd19 && a_v <= 32'd21}, 32'h1);
    rdchk(tec8_pkg::OFS_CONTROL, 32'hc0);
    rdchk(tec8_pkg::OFS_STATUS, 32'h02);
    u_tec8_pulse_src.hold(1'b0, 10);
    u_tec8_pulse_src.hold(1'b1, 10);
    rdchk(tec8_pkg::OFS_COUNT, a_v);
    // overflow reload with a preload written while running
    apb(1'b1, tec8_pkg::OFS_CONTROL, 8'h87);
    apb(1'b1, tec8_pkg::OFS_COUNT, 8'hfd);
    rdchk(tec8_pkg::OFS_COUNT, 32'hfd);
    apb(1'b1, tec8_pkg::OFS_MASK, 8'h01);
    apb(1'b1, tec8_pkg::OFS_CONTROL, 8'h97);
    apb(1'b1, tec8_pkg::OFS_COUNT, 8'h80);
    apb(1'b0, tec8_pkg::OFS_COUNT, 8'h00);
    check({31'h0, rd_v == 32'hfd || rd_v == 32'hfe}, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 600) begin
      n++;
      @(posedge mclk);
    end
    check({31'h0, irq}, 32'h1);
    rdchk(tec8_pkg::OFS_STATUS, 32'h01);
    rdchk(tec8_pkg::OFS_COUNT, 32'h80);
    check({31'h0, irq}, 32'h0);
    // masked event, then unmasked, then cleared by read
    apb(1'b1, tec8_pkg::OFS_CONTROL, 8'h80);
    apb(1'b1, tec8_pkg::OFS_COUNT, 8'hff);
    apb(1'b1, tec8_pkg::OFS_MASK, 8'h00);
    apb(1'b1, tec8_pkg::OFS_CONTROL, 8'h90);
    apb(1'b1, tec8_pkg::OFS_CONTROL, 8'h80);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, tec8_pkg::OFS_MASK, 8'h01);
    @(posedge mclk);
    check({31'h0, irq}, 32'h1);
    rdchk(tec8_pkg::OFS_STATUS, 32'h01);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    // unmapped address is refused
    apb(1'b1, 12'h010, 8'h5a);
    check({31'h0, rd_e}, 32'h1);
    rdchk(12'h010, 32'h00);
    check({31'h0, rd_e}, 32'h1);
    // second reset in mid-run
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rdchk(tec8_pkg::OFS_CONTROL, 32'h08);
    rdchk(tec8_pkg::OFS_COUNT, 32'h00);
    final_report();
  end
endmodule
`default_nettype wire
